/* common/deser_cfg_pkg.sv */
// Constants and types for the deserializer strap and mode configuration block.
// Assumes a single 125 MHz system clock and a 16-bit register port.

package deser_cfg_pkg;

   // ==========================================================
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_CFG0 = 4'h0;
   localparam logic [3:0] ADDR_CFG1 = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;

   // ==========================================================
   // Configuration word 0 fields
   localparam int IFM_LSB = 0;
   localparam int MAP_LSB = 2;
   localparam int LOWB_BIT = 4;
   localparam int SPEN_BIT = 5;
   localparam int EDGE_BIT = 6;
   localparam int DSLEW_BIT = 7;
   localparam int PSLEW_BIT = 8;
   localparam int SLEEP_BIT = 9;
   localparam int HOLD_BIT = 10;
   localparam int REL_BIT = 11;
   localparam logic [15:0] CFG0_RST = 16'h0000;

   // ==========================================================
   // Configuration word 1 fields
   localparam int LEVEL_LSB = 0;
   localparam int RANGE_LSB = 4;
   localparam int OSC_LSB = 8;
   localparam logic [15:0] CFG1_RST = 16'h0000;

   // ==========================================================
   // Status word fields
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_HELD_BIT = 2;
   localparam int ST_TEST_BIT = 3;
   localparam int ST_PD_BIT = 4;

   // ==========================================================
   // Strap positions in the pad vector {pass, red, green, blue}
   localparam int PAD_W = 25;
   localparam int P_EDGE = 1;
   localparam int P_SLEEP = 2;
   localparam int P_DSLEW = 3;
   localparam int P_LOWB = 4;
   localparam int P_PSLEW = 5;
   localparam int P_IFM1 = 6;
   localparam int P_IFM0 = 7;
   localparam int P_OSC_LSB = 8;
   localparam int P_LEVEL_LSB = 12;
   localparam int P_MAP_LSB = 16;
   localparam int P_RANGE_LSB = 19;
   localparam int P_HOLD = 24;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int STRAP_SETTLE_NS = 100;
   localparam logic [7:0] SETTLE_CYC =
      8'((STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // ==========================================================
   // Interface modes
   typedef enum logic [1:0] {
      IFM_NATIVE_RAW = 2'b00,
      IFM_NATIVE_FILT = 2'b01,
      IFM_LEGACY_A = 2'b10,
      IFM_LEGACY_B = 2'b11
   } if_mode_e;

   // Power sequence states
   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_RUN = 4'b0100,
      ST_SLEEP = 4'b1000
   } pwr_state_e;

endpackage : deser_cfg_pkg

/* src/strap_sync.sv */
// Three-stage synchroniser for pad inputs.
// Assumes inputs are asynchronous to sys_clk_i; output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Pad side
   input wire logic [W-1:0] async_i,
   // Clock side
   output logic [W-1:0] sync_o
);

   // ==========================================================
   // Stages
   logic [W-1:0] stage1; // Metastability catcher
   logic [W-1:0] stage2; // Second stage
   logic [W-1:0] stage3; // Third stage
   logic [W-1:0] next_sync; // Filtered value

   // Hold each bit until stages two and three agree
   assign next_sync = (stage2 & stage3) | (sync_o & (stage2 | stage3));

   // Shift chain
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_o <= next_sync;
      end
   end

endmodule : strap_sync

`default_nettype wire

/* src/deser_strap_config.sv */
// Strap capture, register overrides and pad control of the deserializer.
// Assumes lock and received data come from logic on sys_clk_i; pads and
// the power-down and self-test pins are asynchronous.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Mode 00 unfiltered, 01 filtered control signals
// - Modes 10 and 11 pick legacy formats
// - Low-band select picks spreading band
// - Low-band select ignored with spreading off
// - Hold strap keeps outputs low until release
// - Without hold, outputs toggle once locked
// - Sleep select and power-down set sleep pads
// - Outputs tri-state before first power up
// - Strobe select picks rising or falling edge
// - Self-test pin switches self-test on, off
// - Power-down pin high enables, low sleeps
// - Power-down low holds registers in reset
// - Slew select picks increased or normal slew
// - Four-bit strap sets spread range, overridable
// - Four-bit strap sets equalization, overridable
// - Pads sampled as straps during power up
module deser_strap_config
   import deser_cfg_pkg::*;
#(
   parameter logic [7:0] SETTLE = SETTLE_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Control pins
   input wire logic power_down_n_i,
   input wire logic self_test_enable_i,
   // Pad inputs, read as straps
   input wire logic [PAD_W-1:0] pad_i,
   // Received video and status
   input wire logic lock_i,
   input wire logic [23:0] rx_rgb_i,
   input wire logic rx_hs_i,
   input wire logic rx_vs_i,
   input wire logic rx_de_i,
   input wire logic rx_pass_i,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // Parallel pads
   output logic [PAD_W-1:0] pad_o,
   output logic pad_oe_n_o,
   output logic hs_o,
   output logic vs_o,
   output logic de_o,
   output logic ctl_oe_n_o,
   output logic pixclk_run_o,
   output logic pixclk_invert_o,
   // Configuration to the receiver
   output logic deser_enable_o,
   output logic self_test_on_o,
   output logic ctl_filter_en_o,
   output logic [1:0] compat_mode_o,
   output logic [1:0] map_sel_o,
   output logic spread_enable_o,
   output logic spread_low_band_sel_o,
   output logic [3:0] spread_range_sel_o,
   output logic [3:0] rx_equalization_level_o,
   output logic [2:0] oscillator_sel_o,
   output logic data_slew_sel_o,
   output logic pixclk_slew_sel_o
);

   // ==========================================================
   // Pin synchronisers
   logic [PAD_W+1:0] pin_raw; // Pads plus control pins
   logic [PAD_W+1:0] pin_sync; // Filtered copies
   logic [PAD_W-1:0] strap; // Synchronised strap pads
   logic pd_n; // Synchronised power-down pin
   logic test_pin; // Synchronised self-test pin

   assign pin_raw = {self_test_enable_i, power_down_n_i, pad_i};
   assign strap = pin_sync[PAD_W-1:0];
   assign pd_n = pin_sync[PAD_W];
   assign test_pin = pin_sync[PAD_W+1];

   // Three-flop agreement filter for every pin
   strap_sync #(
      .W(PAD_W + 2)
   ) u_pin_sync (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(pin_raw),
      .sync_o(pin_sync)
   );

   // ==========================================================
   // Power sequence
   pwr_state_e state; // Current state
   pwr_state_e next_state; // Next state
   logic [7:0] settle_cnt; // Strap settle counter
   logic [7:0] next_settle_cnt; // Next counter value
   logic settle_done; // Straps stable
   logic strap_load; // One-cycle latch pulse

   assign settle_done = (settle_cnt == SETTLE - 8'h01);
   assign strap_load = (state == ST_SAMPLE) && settle_done && pd_n;

   // State transitions
   always_comb begin
      next_state = state;
      next_settle_cnt = 8'h00;
      case (state)
         ST_OFF: begin
            // Wait for the first release of power-down
            if (pd_n) begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            // Pads are inputs while the straps settle
            if (!pd_n) begin
               next_state = ST_SLEEP;
            end else if (settle_done) begin
               next_state = ST_RUN;
            end else begin
               next_settle_cnt = settle_cnt + 8'h01;
            end
         end
         ST_RUN: begin
            // Normal operation until power-down drops
            if (!pd_n) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // Re-sample straps on each release
            if (pd_n) begin
               next_state = ST_SAMPLE;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_OFF;
         settle_cnt <= 8'h00;
      end else begin
         state <= next_state;
         settle_cnt <= next_settle_cnt;
      end
   end

   // ==========================================================
   // Strap decode into register words
   logic [15:0] strap_cfg0; // Word 0 from straps
   logic [15:0] strap_cfg1; // Word 1 from straps

   // Word 0: mode, map, band, edge, slews, sleep, hold
   assign strap_cfg0 = {
      4'h0,
      1'b0,
      strap[P_HOLD],
      strap[P_SLEEP],
      strap[P_PSLEW],
      strap[P_DSLEW],
      strap[P_EDGE],
      1'b0,
      strap[P_LOWB],
      strap[P_MAP_LSB+1 -: 2],
      strap[P_IFM1],
      strap[P_IFM0]
   };

   // Word 1: oscillator, spread range, equalization
   assign strap_cfg1 = {
      5'h00,
      strap[P_OSC_LSB +: 3],
      strap[P_RANGE_LSB +: 4],
      strap[P_LEVEL_LSB +: 4]
   };

   // ==========================================================
   // Registers
   logic [15:0] cfg0; // Mode and control word
   logic [15:0] cfg1; // Analog setting word
   logic sleep_keep; // Sleep select kept through power-down
   logic wr_cfg0; // Write to word 0
   logic wr_cfg1; // Write to word 1

   assign wr_cfg0 = reg_write_i && (reg_addr_i == ADDR_CFG0) && pd_n;
   assign wr_cfg1 = reg_write_i && (reg_addr_i == ADDR_CFG1) && pd_n;

   // Latch straps, then let writes override
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg0 <= CFG0_RST;
         cfg1 <= CFG1_RST;
      end else if (!pd_n) begin
         cfg0 <= CFG0_RST;
         cfg1 <= CFG1_RST;
      end else begin
         // A write in the latch cycle wins over the strap
         if (wr_cfg0) begin
            cfg0 <= reg_wdata_i;
         end else if (strap_load) begin
            cfg0 <= strap_cfg0;
         end
         if (wr_cfg1) begin
            cfg1 <= reg_wdata_i;
         end else if (strap_load) begin
            cfg1 <= strap_cfg1;
         end
      end
   end

   // Sleep select survives power-down for the pad table
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sleep_keep <= 1'b0;
      end else if (state == ST_RUN) begin
         sleep_keep <= cfg0[SLEEP_BIT];
      end
   end

   // ==========================================================
   // Settings to the receiver
   logic running; // Strap capture finished and enabled
   logic hold_low; // Hold strap active, not yet released
   logic spread_on; // Spreading enabled

   assign running = (state == ST_RUN);
   assign hold_low = cfg0[HOLD_BIT] && !cfg0[REL_BIT];
   assign spread_on = cfg0[SPEN_BIT];

   assign deser_enable_o = running;
   assign self_test_on_o = test_pin && running;
   assign compat_mode_o = cfg0[IFM_LSB +: 2];
   assign ctl_filter_en_o = (cfg0[IFM_LSB +: 2] == IFM_NATIVE_FILT);
   assign map_sel_o = cfg0[MAP_LSB +: 2];
   assign spread_enable_o = spread_on;
   assign spread_low_band_sel_o = spread_on && cfg0[LOWB_BIT];
   assign spread_range_sel_o = cfg1[RANGE_LSB +: 4];
   assign rx_equalization_level_o = cfg1[LEVEL_LSB +: 4];
   assign oscillator_sel_o = cfg1[OSC_LSB +: 3];
   assign data_slew_sel_o = cfg0[DSLEW_BIT];
   assign pixclk_slew_sel_o = cfg0[PSLEW_BIT];

   // ==========================================================
   // Pad drive selection
   logic show_data; // Received data reaches pads
   logic drive_low; // Pads driven low
   logic drive_any; // Pads driven at all
   logic sleep_tri; // Sleep table picks tri-state

   // Sleep select 1 floats the pads, 0 drives them low
   assign sleep_tri = running ? cfg0[SLEEP_BIT] : sleep_keep;
   assign show_data = running && lock_i && !hold_low;
   assign drive_low = (running && hold_low)
      || (running && !lock_i && !sleep_tri)
      || ((state == ST_SLEEP) && !sleep_tri);
   // Off and sample states keep pads as inputs
   assign drive_any = show_data || drive_low;

   // Registered pad outputs
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pad_o <= '0;
         hs_o <= 1'b0;
         vs_o <= 1'b0;
         de_o <= 1'b0;
         pad_oe_n_o <= 1'b1;
         ctl_oe_n_o <= 1'b1;
         pixclk_run_o <= 1'b0;
      end else begin
         pad_oe_n_o <= !drive_any;
         ctl_oe_n_o <= !drive_any;
         pixclk_run_o <= show_data;
         if (show_data) begin
            // Live video to pads
            pad_o <= {rx_pass_i, rx_rgb_i};
            hs_o <= rx_hs_i;
            vs_o <= rx_vs_i;
            de_o <= rx_de_i;
         end else begin
            // Held low or floating
            pad_o <= '0;
            hs_o <= 1'b0;
            vs_o <= 1'b0;
            de_o <= 1'b0;
         end
      end
   end

   // Edge select 1: data change on falling edge, captured on rising
   assign pixclk_invert_o = !cfg0[EDGE_BIT];

   // ==========================================================
   // Register read
   logic [15:0] status; // Live status word
   logic [15:0] rd_mux; // Selected read word

   assign status = {
      11'h000,
      !pd_n,
      self_test_on_o,
      hold_low,
      running,
      lock_i
   };

   assign rd_mux = (reg_addr_i == ADDR_CFG0) ? cfg0
      : (reg_addr_i == ADDR_CFG1) ? cfg1
      : (reg_addr_i == ADDR_STAT) ? status
      : 16'h0000;

   // Read data stands for one cycle only
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_read_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

endmodule : deser_strap_config

`default_nettype wire

/* tb/strap_board.sv */
// Board model: strap resistors seen on the shared pads.
// Assumes unstrapped pads read low through their pulldowns.
`timescale 1ns/1ps
`default_nettype none
module strap_board
   import deser_cfg_pkg::*;
(
   // Strap levels and device pads
   input wire logic [PAD_W-1:0] straps_i,
   input wire logic [PAD_W-1:0] pad_o,
   input wire logic pad_oe_n_o,
   // Wire level back to the device
   output logic [PAD_W-1:0] pad_i
);
   // Released pads fall to the resistor levels
   assign pad_i = pad_oe_n_o ? straps_i : pad_o;
endmodule : strap_board
`default_nettype wire

/* tb/deser_strap_config_chk.sv */
// Port checker for the strap configuration block.
// Assumes it is bound to deser_strap_config.
`timescale 1ns/1ps
`default_nettype none
module deser_strap_config_chk
   import deser_cfg_pkg::*;
#(
   parameter logic [7:0] SETTLE = SETTLE_CYC
) (
   // Clock, reset, pins
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic power_down_n_i,
   input wire logic lock_i,
   input wire logic [23:0] rx_rgb_i,
   input wire logic rx_pass_i,
   // Pads and configuration
   input wire logic [PAD_W-1:0] pad_o,
   input wire logic pad_oe_n_o,
   input wire logic ctl_oe_n_o,
   input wire logic pixclk_run_o,
   input wire logic deser_enable_o,
   input wire logic self_test_on_o,
   input wire logic ctl_filter_en_o,
   input wire logic [1:0] compat_mode_o,
   input wire logic spread_enable_o,
   input wire logic spread_low_band_sel_o,
   input wire logic [3:0] rx_equalization_level_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================
   // Has run since reset
   logic ever_run;
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ever_run <= 1'b0;
      end else if (deser_enable_o) begin
         ever_run <= 1'b1;
      end
   end
   // ==========================
   // Assertions
   a_filter_mode: assert property (ctl_filter_en_o == (compat_mode_o == 2'b01))
      else $error("filter enable disagrees with mode");
   a_legacy_mode: assert property (compat_mode_o[1] |-> !ctl_filter_en_o)
      else $error("filter on in legacy mode");
   a_band_gate: assert property (!spread_enable_o |-> !spread_low_band_sel_o)
      else $error("low band without spreading");
   a_never_powered: assert property (!ever_run && !deser_enable_o |-> pad_oe_n_o && ctl_oe_n_o)
      else $error("pads driven before power up");
   a_live_video: assert property (pixclk_run_o |->
      pad_o == {$past(rx_pass_i), $past(rx_rgb_i)} && $past(lock_i) && !pad_oe_n_o)
      else $error("live pads not last received data");
   a_test_gate: assert property (self_test_on_o |-> deser_enable_o)
      else $error("self-test on while down");
   a_pd_stops: assert property ($fell(power_down_n_i) |-> ##[1:8] !deser_enable_o)
      else $error("power down not taken");
   a_pd_clears: assert property ((!power_down_n_i) [*8] |->
      rx_equalization_level_o == 4'h0 && !spread_enable_o)
      else $error("config not cleared in power down");
   a_sleep_dark: assert property (!deser_enable_o ##1 !deser_enable_o |-> !pixclk_run_o)
      else $error("video live in sleep");
   // Main scenarios
   c_live: cover property ($rose(pixclk_run_o));
   c_sleep: cover property ($fell(deser_enable_o));
   c_filter: cover property (ctl_filter_en_o && deser_enable_o);
   c_test: cover property (self_test_on_o);
endmodule : deser_strap_config_chk
bind deser_strap_config deser_strap_config_chk #(.SETTLE(SETTLE)) deser_strap_config_chk_inst (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .power_down_n_i(power_down_n_i),
   .lock_i(lock_i), .rx_rgb_i(rx_rgb_i), .rx_pass_i(rx_pass_i), .pad_o(pad_o),
   .pad_oe_n_o(pad_oe_n_o), .ctl_oe_n_o(ctl_oe_n_o), .pixclk_run_o(pixclk_run_o),
   .deser_enable_o(deser_enable_o), .self_test_on_o(self_test_on_o),
   .ctl_filter_en_o(ctl_filter_en_o), .compat_mode_o(compat_mode_o),
   .spread_enable_o(spread_enable_o), .spread_low_band_sel_o(spread_low_band_sel_o),
   .rx_equalization_level_o(rx_equalization_level_o));
`default_nettype wire

/* tb/test_deser_strap_mode_config.sv */
// Self-checking bench for the strap configuration block.
// Assumes the board model drives the shared pads while they float.
`timescale 1ns/1ps
`default_nettype none
module test_deser_strap_mode_config;
   import deser_cfg_pkg::*;
   // ==========================
   // Signals
   logic sys_clk_i, reset_n_i, power_down_n_i, self_test_enable_i, lock_i;
   logic rx_hs_i, rx_vs_i, rx_de_i, rx_pass_i, reg_write_i, reg_read_i;
   logic [23:0] rx_rgb_i;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, rd_v, v;
   logic [24:0] pad_i, pad_o, st;
   logic pad_oe_n_o, ctl_oe_n_o, pixclk_invert_o, deser_enable_o, self_test_on_o;
   logic ctl_filter_en_o, spread_enable_o, spread_low_band_sel_o;
   logic [1:0] compat_mode_o, map_sel_o;
   logic [3:0] spread_range_sel_o, rx_equalization_level_o;
   logic [2:0] oscillator_sel_o;
   logic data_slew_sel_o, pixclk_slew_sel_o;
   logic hs_o, vs_o, de_o, pixclk_run_o;
   integer seed, miscompares, check_count, cycles, n;
   // ==========================
   // Design and board
   deser_strap_config #(.SETTLE(8'h02)) deser_strap_config_inst (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .power_down_n_i(power_down_n_i),
      .self_test_enable_i(self_test_enable_i), .pad_i(pad_i), .lock_i(lock_i),
      .rx_rgb_i(rx_rgb_i), .rx_hs_i(rx_hs_i), .rx_vs_i(rx_vs_i), .rx_de_i(rx_de_i),
      .rx_pass_i(rx_pass_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
      .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .hs_o(hs_o), .vs_o(vs_o), .de_o(de_o),
      .ctl_oe_n_o(ctl_oe_n_o), .pixclk_run_o(pixclk_run_o), .pixclk_invert_o(pixclk_invert_o),
      .deser_enable_o(deser_enable_o), .self_test_on_o(self_test_on_o),
      .ctl_filter_en_o(ctl_filter_en_o), .compat_mode_o(compat_mode_o),
      .map_sel_o(map_sel_o), .spread_enable_o(spread_enable_o),
      .spread_low_band_sel_o(spread_low_band_sel_o), .spread_range_sel_o(spread_range_sel_o),
      .rx_equalization_level_o(rx_equalization_level_o), .oscillator_sel_o(oscillator_sel_o),
      .data_slew_sel_o(data_slew_sel_o), .pixclk_slew_sel_o(pixclk_slew_sel_o));
   strap_board strap_board_inst (.straps_i(st), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o),
      .pad_i(pad_i));
   // ==========================
   // Clock and hang guard
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         wrap_up();
      end
   end
   // ==========================
   // Helpers
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tick(input integer k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_write_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_read_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask : rd
   task automatic power(input logic on);
      @(posedge sys_clk_i);
      power_down_n_i <= on;
      for (n = 0; n < 60 && deser_enable_o !== on; n = n + 1) tick(1);
      check("enable", deser_enable_o, on);
   endtask : power
   // Expected equalization, range and oscillator word
   function automatic logic [15:0] cfg1_exp(input logic [24:0] s);
      return {5'h00, s[10:8], s[22:19], s[15:12]};
   endfunction : cfg1_exp
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   // ==========================
   // Main sequence
   initial begin
      {reset_n_i, power_down_n_i, self_test_enable_i, lock_i, reg_write_i, reg_read_i} = 6'h00;
      {rx_hs_i, rx_vs_i, rx_de_i, rx_pass_i, rx_rgb_i, reg_addr_i, reg_wdata_i} = '0;
      seed = 32'hfbdc;
      miscompares = 0;
      check_count = 0;
      cycles = 0;
      st = 25'($random(seed)) & 25'h0fc_ffff; // Map straps normal, hold off
      repeat (20) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      tick(2);
      check("oe before power", {pad_oe_n_o, ctl_oe_n_o}, 2'b11);
      power(1'b1);
      rd(ADDR_CFG1, rd_v);
      check("cfg1 straps", rd_v, cfg1_exp(st));
      check("mode", compat_mode_o, {st[P_IFM1], st[P_IFM0]});
      check("slews", {data_slew_sel_o, pixclk_slew_sel_o}, {st[3], st[5]});
      check("invert", pixclk_invert_o, !st[P_EDGE]);
      check("band off", {spread_low_band_sel_o, map_sel_o}, 3'h0);
      $display("test straps done");
      for (n = 0; n < 5; n = n + 1) begin
         wr(ADDR_CFG0, 16'(n[1:0]) | (16'(n < 4) << SPEN_BIT) | 16'h0010);
         tick(1);
         check("filter", ctl_filter_en_o, n[1:0] == 2'b01);
         check("compat", compat_mode_o, n[1:0]);
         check("band", {spread_enable_o, spread_low_band_sel_o}, {2{n < 4}});
      end
      v = 16'($random(seed)) & 16'h07FF;
      wr(ADDR_CFG1, v);
      rd(ADDR_CFG1, rd_v);
      check("cfg1 write", {rd_v, rx_equalization_level_o}, {v, v[3:0]});
      check("range", {spread_range_sel_o, oscillator_sel_o}, {v[7:4], v[10:8]});
      rd(4'hC, rd_v);
      check("unmapped", rd_v, 16'h0000);
      $display("test registers done");
      @(posedge sys_clk_i);
      rx_rgb_i <= 24'($random(seed));
      rx_pass_i <= 1'b1;
      rx_hs_i <= 1'b1;
      rx_vs_i <= 1'b1;
      rx_de_i <= 1'b1;
      lock_i <= 1'b1;
      self_test_enable_i <= 1'b1;
      tick(6);
      check("live pads", {pad_oe_n_o, pad_o}, {1'b0, rx_pass_i, rx_rgb_i});
      check("live ctl", {hs_o, vs_o, de_o, ctl_oe_n_o, pixclk_run_o}, 5'b11101);
      check("self test", self_test_on_o, 1'b1);
      rd(ADDR_STAT, rd_v);
      v = 16'((1 << ST_LOCK_BIT) | (1 << ST_RUN_BIT) | (1 << ST_TEST_BIT));
      check("status live", rd_v, v);
      wr(ADDR_CFG0, 16'h0200);
      power(1'b0);
      wr(ADDR_CFG1, 16'h000f);
      tick(2);
      check("sleep float", {pad_oe_n_o, ctl_oe_n_o, self_test_on_o}, 3'b110);
      check("pd clear", rx_equalization_level_o, 4'h0);
      $display("test sleep done");
      st = 25'h100_0000; // Hold strap alone, sleep select low so sleep drives pads low
      power(1'b1);
      tick(3);
      check("held low", {pad_oe_n_o, pad_o}, 26'h0);
      check("held ctl", {hs_o, vs_o, de_o, ctl_oe_n_o, pixclk_run_o}, 5'b00000);
      rd(ADDR_STAT, rd_v);
      v = 16'((1 << ST_LOCK_BIT) | (1 << ST_RUN_BIT) | (1 << ST_HELD_BIT) | (1 << ST_TEST_BIT));
      check("status held", rd_v, v);
      wr(ADDR_CFG0, 16'h0C00);
      tick(3);
      check("released", pad_o, {rx_pass_i, rx_rgb_i});
      check("released ctl", {hs_o, vs_o, de_o, pixclk_run_o}, 4'hf);
      power(1'b0);
      tick(2);
      check("sleep low", {pad_oe_n_o, pad_o}, 26'h0);
      check("sleep ctl", {hs_o, vs_o, de_o, ctl_oe_n_o, pixclk_run_o}, 5'b00000);
      $display("test hold done");
      wrap_up();
   end
endmodule : test_deser_strap_mode_config
`default_nettype wire
